// >>> tcsc_sys_config.v
/*
 system configuration register bank of a dual-engine timer coprocessor:
 apb slave with global flags, code-store signature checker, code
 visibility, global timebase enable and coherent two-parameter mover.
 assumes code-store and parameter ram ports answer reads one cycle
 after the address, and engine event inputs are on core_clk_i.
*/
`timescale 1ns/1ps
`include "tcsc_defs.vh"

// Summary of operation
// - global clear wipes all exception flags
// - clear ignores engine stop modes
// - microcode exception flags stick until clear
// - illegal instruction flags stick until clear
// - read-only code store block count minus one
// - pass end signature mismatch sets flag
// - mismatch cleared by enable rise, clear
// - disabled checker held at first address
// - checker loops all words accumulating crc
// - enable writable, self-clears on mismatch
// - hidden code store gives bus error
// - visibility writes need halted/stopped engines
// - visibility locks low-power disable bits
// - timebase enable starts all timebases
// - start bit moves pair, waits, self-clears
// - target address from base and number
// - buffer address from buffer base
// - width select keeps upper byte
// - direction picks copy source
// - first parameter moved before second
// - expected signature register compared each pass
module tcsc_sys_config #(
  parameter CS_AW = 12,
  parameter [4:0] CS_BLOCKS_M1 = `TCSC_BLOCKS_M1,
  parameter [31:0] CRC_POLY = `TCSC_CRC_POLY,
  parameter [31:0] CRC_SEED = `TCSC_CRC_SEED,
  parameter PR_AW = 10,
  parameter [31:0] PR_BASE = `TCSC_PR_BASE
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire cs_space_i,
  input wire exc_a_i,
  input wire exc_b_i,
  input wire bad_a_i,
  input wire bad_b_i,
  input wire quiet_a_i,
  input wire quiet_b_i,
  input wire peer_tbe_i,
  output reg tbe_o,
  output reg lp_lock_o,
  output reg cs_vis_o,
  output reg [CS_AW-1:0] cs_addr_o,
  input wire [31:0] cs_data_i,
  output reg pr_en_o,
  output reg pr_we_o,
  output reg [3:0] pr_be_o,
  output reg [PR_AW-1:0] pr_addr_o,
  output reg [31:0] pr_wdata_o,
  input wire [31:0] pr_rdata_i
);

  localparam S_IDLE = 3'd0;
  localparam S_RD0 = 3'd1;
  localparam S_WR0 = 3'd2;
  localparam S_RD1 = 3'd3;
  localparam S_WR1 = 3'd4;
  localparam S_DONE = 3'd5;
  localparam [CS_AW-1:0] CS_LAST = {CS_AW{1'b1}};

  reg exc_a;
  reg exc_b;
  reg bad_a;
  reg bad_b;
  reg misf;
  reg chken;
  reg code_visibility;
  reg tbe;
  reg [4:0] tbase;
  reg [9:0] bbase;
  reg wide;
  reg dir;
  reg start;
  reg [6:0] p0;
  reg [6:0] p1;
  reg [31:0] sig_exp;
  reg [31:0] crc;
  reg [31:0] next_crc;
  reg [2:0] st;
  reg chk_rd;
  reg chk_last;
  reg launched;
  reg [31:0] rd_word;
  integer i;

  wire acc = psel_i & penable_i;
  wire [11:0] off = paddr_i[11:0];
  wire hit_cfg = off == `TCSC_OFF_CFG;
  wire hit_xfer = off == `TCSC_OFF_XFER;
  wire hit_sig = off == `TCSC_OFF_SIG;
  wire mapped = hit_cfg | hit_xfer | hit_sig;
  // transfer register stalls while mover runs
  wire busy = (st != S_IDLE) | start;
  wire stall = busy & hit_xfer;
  // writes land once, on the first unstalled access edge
  wire wr = acc & pwrite_i & ~pready_o & ~launched & ~stall;
  wire gclr = wr & hit_cfg & ~cs_space_i & pwdata_i[`TCSC_B_GCLR];
  wire chk_set = wr & hit_cfg & ~cs_space_i & pwdata_i[`TCSC_B_CHKEN];
  wire chk_wr = wr & hit_cfg & ~cs_space_i;
  // visibility writable only with engines quiet
  wire vis_ok = chk_wr & quiet_a_i & quiet_b_i;
  wire vis_rise = vis_ok & pwdata_i[`TCSC_B_VIS] & ~code_visibility;
  // compare on last word of pass
  wire mis_now = chk_last & (next_crc != sig_exp);
  wire xfer_go = wr & hit_xfer & ~cs_space_i & pwdata_i[`TCSC_B_START];

  // target word index from base and number
  wire [11:0] tgt0_w = {tbase, p0};
  wire [11:0] tgt1_w = {tbase, p1};
  wire [PR_AW-1:0] pr_off = PR_BASE[PR_AW+1:2];
  wire [PR_AW-1:0] tgt0 = tgt0_w[PR_AW-1:0] + pr_off;
  wire [PR_AW-1:0] tgt1 = tgt1_w[PR_AW-1:0] + pr_off;
  wire [11:0] buf0_w = {1'b0, bbase, 1'b0};
  wire [11:0] buf1_w = {1'b0, bbase, 1'b1};
  wire [PR_AW-1:0] buf0 = buf0_w[PR_AW-1:0] + pr_off;
  wire [PR_AW-1:0] buf1 = buf1_w[PR_AW-1:0] + pr_off;
  wire [3:0] wr_be = wide ? 4'hf : 4'h7;

  wire [31:0] cfg_word = {
    1'b0,
    3'h0,
    exc_a,
    exc_b,
    bad_a,
    bad_b,
    3'h0,
    CS_BLOCKS_M1,
    5'h00,
    misf,
    chken,
    2'h0,
    code_visibility,
    5'h00,
    tbe
  };
  wire [31:0] xfer_word = {
    start,
    tbase,
    bbase,
    wide,
    p0,
    dir,
    p1
  };

  always @* begin
    next_crc = crc;
    for (i = 31; i >= 0; i = i - 1) begin
      if (next_crc[31] ^ cs_data_i[i]) begin
        next_crc = {next_crc[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        next_crc = {next_crc[30:0], 1'b0};
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      exc_a <= 1'b0;
      exc_b <= 1'b0;
      bad_a <= 1'b0;
      bad_b <= 1'b0;
    end else begin
      exc_a <= exc_a_i | (exc_a & ~gclr);
      exc_b <= exc_b_i | (exc_b & ~gclr);
      bad_a <= bad_a_i | (bad_a & ~gclr);
      bad_b <= bad_b_i | (bad_b & ~gclr);
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      misf <= 1'b0;
      chken <= 1'b0;
      code_visibility <= 1'b0;
      tbe <= 1'b0;
      sig_exp <= `TCSC_RST_WORD;
    end else begin
      if (mis_now) begin
        misf <= 1'b1;
      end else if (gclr | (chk_set & ~chken)) begin
        misf <= 1'b0;
      end
      if (mis_now & ~misf) begin
        chken <= 1'b0;
      end else if (chk_wr) begin
        chken <= pwdata_i[`TCSC_B_CHKEN];
      end
      if (vis_ok) begin
        code_visibility <= pwdata_i[`TCSC_B_VIS];
      end
      if (chk_wr) begin
        tbe <= pwdata_i[`TCSC_B_TBE];
      end
      if (wr & hit_sig & ~cs_space_i) begin
        sig_exp <= pwdata_i;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_addr_o <= {CS_AW{1'b0}};
      crc <= CRC_SEED;
      chk_rd <= 1'b0;
      chk_last <= 1'b0;
    end else if (~chken | vis_rise | mis_now) begin
      cs_addr_o <= {CS_AW{1'b0}};
      crc <= CRC_SEED;
      chk_rd <= 1'b0;
      chk_last <= 1'b0;
    end else begin
      chk_rd <= 1'b1;
      chk_last <= cs_addr_o == CS_LAST;
      cs_addr_o <= cs_addr_o + {{(CS_AW-1){1'b0}}, 1'b1};
      if (chk_rd) begin
        crc <= chk_last ? CRC_SEED : next_crc;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= S_IDLE;
      start <= 1'b0;
      tbase <= 5'h00;
      bbase <= 10'h000;
      wide <= 1'b0;
      dir <= 1'b0;
      p0 <= 7'h00;
      p1 <= 7'h00;
      pr_en_o <= 1'b0;
      pr_we_o <= 1'b0;
      pr_be_o <= 4'h0;
      pr_addr_o <= {PR_AW{1'b0}};
      pr_wdata_o <= `TCSC_RST_WORD;
    end else begin
      pr_en_o <= 1'b0;
      pr_we_o <= 1'b0;
      case (st)
        S_IDLE: begin
          if (wr & hit_xfer & ~cs_space_i) begin
            start <= pwdata_i[`TCSC_B_START];
            tbase <= pwdata_i[`TCSC_F_TB_HI:`TCSC_F_TB_LO];
            bbase <= pwdata_i[`TCSC_F_BB_HI:`TCSC_F_BB_LO];
            wide <= pwdata_i[`TCSC_B_WIDE];
            p0 <= pwdata_i[`TCSC_F_P0_HI:`TCSC_F_P0_LO];
            dir <= pwdata_i[`TCSC_B_DIR];
            p1 <= pwdata_i[`TCSC_F_P1_HI:`TCSC_F_P1_LO];
            if (xfer_go) begin
              st <= S_RD0;
            end
          end
        end
        S_RD0, S_RD1: begin
          pr_en_o <= 1'b1;
          pr_be_o <= 4'hf;
          if (st == S_RD0) begin
            pr_addr_o <= dir ? buf0 : tgt0;
            st <= S_WR0;
          end else begin
            pr_addr_o <= dir ? buf1 : tgt1;
            st <= S_WR1;
          end
        end
        S_WR0, S_WR1: begin
          if (~pr_en_o) begin
            pr_en_o <= 1'b1;
            pr_we_o <= 1'b1;
            pr_be_o <= wr_be;
            pr_wdata_o <= pr_rdata_i;
            if (st == S_WR0) begin
              pr_addr_o <= dir ? tgt0 : buf0;
              st <= S_RD1;
            end else begin
              pr_addr_o <= dir ? tgt1 : buf1;
              st <= S_DONE;
            end
          end
        end
        S_DONE: begin
          start <= 1'b0;
          st <= S_IDLE;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // read mux; code store space reads zero
  always @* begin
    rd_word = `TCSC_RST_WORD;
    if (~cs_space_i) begin
      case (off)
        `TCSC_OFF_CFG: begin
          rd_word = cfg_word;
        end
        `TCSC_OFF_XFER: begin
          rd_word = xfer_word;
        end
        `TCSC_OFF_SIG: begin
          rd_word = sig_exp;
        end
        default: begin
          rd_word = `TCSC_RST_WORD;
        end
      endcase
    end
  end

  // apb answer in access phase only
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o <= `TCSC_RST_WORD;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      tbe_o <= 1'b0;
      lp_lock_o <= 1'b0;
      cs_vis_o <= 1'b0;
      launched <= 1'b0;
    end else begin
      tbe_o <= tbe | peer_tbe_i;
      lp_lock_o <= code_visibility;
      cs_vis_o <= code_visibility;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      if (xfer_go) begin
        launched <= 1'b1;
      end
      if (acc & ~pready_o & ~stall & ~xfer_go) begin
        pready_o <= 1'b1;
        launched <= 1'b0;
        pslverr_o <= cs_space_i ? ~code_visibility : ~mapped;
        prdata_o <= rd_word;
      end
    end
  end

endmodule

// >>> tcsc_defs.vh
/*
 constants for the timer coprocessor system configuration block:
 register offsets, field positions, reset values.
 assumes apb byte addressing with word-aligned registers.
*/
`ifndef TCSC_DEFS_VH
`define TCSC_DEFS_VH

`define TCSC_OFF_CFG 12'h000
`define TCSC_OFF_XFER 12'h004
`define TCSC_OFF_SIG 12'h00c

// config/status fields (bit 0 = lsb)
`define TCSC_B_GCLR 31
`define TCSC_B_EXC_A 27
`define TCSC_B_EXC_B 26
`define TCSC_B_BAD_A 25
`define TCSC_B_BAD_B 24
`define TCSC_F_BLK_HI 20
`define TCSC_F_BLK_LO 16
`define TCSC_B_MISF 10
`define TCSC_B_CHKEN 9
`define TCSC_B_VIS 6
`define TCSC_B_TBE 0

// transfer control fields
`define TCSC_B_START 31
`define TCSC_F_TB_HI 30
`define TCSC_F_TB_LO 26
`define TCSC_F_BB_HI 25
`define TCSC_F_BB_LO 16
`define TCSC_B_WIDE 15
`define TCSC_F_P0_HI 14
`define TCSC_F_P0_LO 8
`define TCSC_B_DIR 7
`define TCSC_F_P1_HI 6
`define TCSC_F_P1_LO 0

`define TCSC_RST_WORD 32'h0000_0000
`define TCSC_PR_BASE 32'h0000_8000
`define TCSC_BLOCKS_M1 5'h07
`define TCSC_CRC_POLY 32'h04c1_1db7
`define TCSC_CRC_SEED 32'hffff_ffff
`define TCSC_BLK_BYTES 2048
`define TCSC_HI_BYTE_MASK 32'hff00_0000

`endif

// >>> tcsc_sys_config_asserts.sv
/* port checker for the config block.
 assumes bind onto tcsc_sys_config. */
`timescale 1ns/1ps
module tcsc_sys_config_asserts (
  input wire core_clk_i,
  input wire srst_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire cs_space_i,
  input wire quiet_a_i,
  input wire quiet_b_i,
  input wire peer_tbe_i,
  input wire tbe_o,
  input wire lp_lock_o,
  input wire cs_vis_o,
  input wire pr_en_o,
  input wire pr_we_o,
  input wire [3:0] pr_be_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  property p_rdy_pulse; pready_o |=> !pready_o; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready held too long");
  property p_err_rdy; pslverr_o |-> pready_o; endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("error without ready");
  property p_cs_err; pready_o && cs_space_i && !cs_vis_o |-> pslverr_o;
  endproperty
  a_cs_err: assert property (p_cs_err)
    else $error("hidden store access not refused");
  property p_vis_quiet;
    $rose(cs_vis_o) |-> $past(quiet_a_i && quiet_b_i, 2);
  endproperty
  a_vis_quiet: assert property (p_vis_quiet)
    else $error("visibility set while engine running");
  property p_lock; lp_lock_o == cs_vis_o; endproperty
  a_lock: assert property (p_lock)
    else $error("lock differs from visibility");
  property p_tbe; peer_tbe_i |=> tbe_o; endproperty
  a_tbe: assert property (p_tbe)
    else $error("peer enable did not start timebase");
  property p_be; pr_we_o |-> pr_en_o && pr_be_o[2:0] == 3'h7; endproperty
  a_be: assert property (p_be)
    else $error("bad parameter write strobe");
  property p_rd_wr; pr_en_o && !pr_we_o |-> ##[1:2] (pr_en_o && pr_we_o);
  endproperty
  a_rd_wr: assert property (p_rd_wr)
    else $error("read not followed by write");
  c_err: cover property (pslverr_o);
  c_vis: cover property ($rose(cs_vis_o));
  c_wr: cover property (pr_we_o);
endmodule
bind tcsc_sys_config tcsc_sys_config_asserts i_chk (.core_clk_i,
  .srst_i, .pready_o, .pslverr_o, .cs_space_i, .quiet_a_i, .quiet_b_i,
  .peer_tbe_i, .tbe_o, .lp_lock_o, .cs_vis_o, .pr_en_o, .pr_we_o,
  .pr_be_o);

// >>> tcsc_mem_model.sv
/* parameter ram and code store model.
 assumes reads answer one cycle after the request. */
`timescale 1ns/1ps
module tcsc_mem_model (
  input wire core_clk_i,
  input wire pr_en_i,
  input wire pr_we_i,
  input wire [3:0] pr_be_i,
  input wire [9:0] pr_addr_i,
  input wire [31:0] pr_wdata_i,
  output logic [31:0] pr_rdata_o,
  input wire [11:0] cs_addr_i,
  output logic [31:0] cs_data_o
);
  logic [31:0] mem [0:1023];
  always @(posedge core_clk_i) begin
    cs_data_o <= 32'h5a00_0000 | {20'h0, cs_addr_i};
    if (pr_en_i && !pr_we_i)
      pr_rdata_o <= mem[pr_addr_i];
    else
      pr_rdata_o <= ~pr_rdata_o;
    for (int i = 0; i < 4; i++)
      if (pr_en_i && pr_we_i && pr_be_i[i])
        mem[pr_addr_i][8*i+:8] <= pr_wdata_i[8*i+:8];
  end
endmodule

// >>> tcsc_sys_config_tb.sv
/* self-checking bench for the config block.
 assumes the memory model and checker files. */
`timescale 1ns/1ps
`include "tcsc_defs.vh"
module tcsc_sys_config_tb;
  logic core_clk_i, srst_i, psel_i, penable_i, pwrite_i, cs_space_i;
  logic exc_a_i, exc_b_i, bad_a_i, bad_b_i, quiet_a_i, quiet_b_i;
  logic peer_tbe_i, pready_o, pslverr_o, tbe_o, lp_lock_o, cs_vis_o;
  logic pr_en_o, pr_we_o, er;
  logic [31:0] paddr_i, pwdata_i, prdata_o, cs_data_i, rd;
  logic [31:0] pr_wdata_o, pr_rdata_i;
  logic [3:0] pr_be_o;
  logic [9:0] pr_addr_o;
  logic [11:0] cs_addr_o;
  int error_cnt, check_count;
  tcsc_sys_config i_dut (.core_clk_i, .srst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .cs_space_i, .exc_a_i, .exc_b_i, .bad_a_i, .bad_b_i, .quiet_a_i,
    .quiet_b_i, .peer_tbe_i, .tbe_o, .lp_lock_o, .cs_vis_o, .cs_addr_o,
    .cs_data_i, .pr_en_o, .pr_we_o, .pr_be_o, .pr_addr_o, .pr_wdata_o,
    .pr_rdata_i);
  tcsc_mem_model i_mem (.core_clk_i, .pr_en_i(pr_en_o), .pr_we_i(pr_we_o),
    .pr_be_i(pr_be_o), .pr_addr_i(pr_addr_o), .pr_wdata_i(pr_wdata_o),
    .pr_rdata_o(pr_rdata_i), .cs_addr_i(cs_addr_o), .cs_data_o(cs_data_i));
  initial begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= {20'h0, a};
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      end_sim;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task t_flags;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      {quiet_b_i, quiet_a_i} <= i[1:0];
      {exc_a_i, exc_b_i, bad_a_i, bad_b_i} <= 4'hf;
      @(posedge core_clk_i);
      {exc_a_i, exc_b_i, bad_a_i, bad_b_i} <= 4'h0;
      apb(1, `TCSC_OFF_CFG, 0);
      apb(0, `TCSC_OFF_CFG, 0);
      chk(rd[27:24], 4'hf);
      apb(1, `TCSC_OFF_CFG, 32'h8000_0000);
      apb(0, `TCSC_OFF_CFG, 0);
      chk(rd & 32'h8f00_0400, 0);
    end
  endtask
  task t_vis;
    @(posedge core_clk_i);
    quiet_a_i <= 0;
    apb(1, `TCSC_OFF_CFG, 32'h40);
    @(posedge core_clk_i);
    chk(cs_vis_o, 0);
    cs_space_i <= 1;
    apb(0, 12'h000, 0);
    chk(er, 1);
    cs_space_i <= 0;
    quiet_a_i <= 1;
    apb(1, `TCSC_OFF_CFG, 32'h40);
    @(posedge core_clk_i);
    chk(lp_lock_o, 1);
    chk(cs_vis_o, 1);
    cs_space_i <= 1;
    apb(0, 12'h000, 0);
    chk(er, 0);
    cs_space_i <= 0;
  endtask
  task t_tbe;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      peer_tbe_i <= i[1];
      apb(1, `TCSC_OFF_CFG, {31'h0, i[0]});
      repeat (2) @(posedge core_clk_i);
      chk(tbe_o, i != 0);
    end
    peer_tbe_i <= 0;
  endtask
  task t_xfer;
    i_mem.mem[4] = 32'h1122_3344;
    i_mem.mem[5] = 32'h5566_7788;
    i_mem.mem[131] = 32'haabb_ccdd;
    i_mem.mem[137] = 32'h0;
    apb(1, `TCSC_OFF_XFER, 32'h8402_0389);
    apb(0, `TCSC_OFF_XFER, 0);
    chk(rd[31], 0);
    chk(i_mem.mem[131], 32'haa22_3344);
    chk(i_mem.mem[137], 32'h0066_7788);
    apb(1, `TCSC_OFF_XFER, 32'h8402_8989);
    chk(i_mem.mem[137], 32'h5566_7788);
    apb(1, `TCSC_OFF_XFER, 32'h8402_8309);
    chk(i_mem.mem[4], 32'haa22_3344);
    i_mem.mem[4] = 32'h0;
    apb(1, `TCSC_OFF_XFER, 32'h8402_0309);
    chk(i_mem.mem[4], 32'h0022_3344);
  endtask
  task t_checker;
    apb(1, `TCSC_OFF_SIG, 0);
    apb(1, `TCSC_OFF_CFG, 32'h200);
    repeat (6000) @(posedge core_clk_i);
    apb(0, `TCSC_OFF_CFG, 0);
    chk(rd[10:9], 2'b10);
    apb(1, `TCSC_OFF_CFG, 32'h200);
    apb(0, `TCSC_OFF_CFG, 0);
    chk(rd[10], 0);
    apb(1, `TCSC_OFF_CFG, 0);
    repeat (3) @(posedge core_clk_i);
    chk(cs_addr_o, 0);
  endtask
  initial begin
    srst_i = 1;
    {psel_i, penable_i, pwrite_i, cs_space_i, peer_tbe_i} = 5'h0;
    {exc_a_i, exc_b_i, bad_a_i, bad_b_i, quiet_a_i, quiet_b_i} = 6'h0;
    paddr_i = 0;
    pwdata_i = 0;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 0;
    apb(0, `TCSC_OFF_CFG, 0);
    chk(rd, 32'h0007_0000);
    apb(0, 12'h008, 0);
    chk(er, 1);
    apb(1, `TCSC_OFF_SIG, 32'hc3a5_965a);
    apb(0, `TCSC_OFF_SIG, 0);
    chk(rd, 32'hc3a5_965a);
    t_flags;
    t_vis;
    t_tbe;
    t_xfer;
    t_checker;
    end_sim;
  end
endmodule
